/* shared/pmic_seq_pkg.sv */
`default_nettype none
package pmic_seq_pkg;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NUM_OUT  = 5;
  localparam int NUM_GPIO = 7;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] LP_CFG_OFS   = 8'h08;
  localparam logic [7:0] DELAY_BASE   = 8'h10;
  localparam logic [7:0] VSET_BASE    = 8'h30;
  localparam logic [7:0] REG_STRIDE   = 8'h04;

  // Field positions
  localparam int BUS_BIT_POS   = 9;
  localparam int LP_OFF_POS    = 0;
  localparam int LP_DEEP_POS   = 5;
  localparam int LP_SLEEP_POS  = 10;
  localparam int ST_ENABLE_POS = 0;
  localparam int ST_RAMP_POS   = 5;
  localparam int ST_AUX_POS    = 10;
  localparam int ST_FAULT_POS  = 11;
  localparam int ST_SCALE_POS  = 12;

  // Reset values
  localparam logic [2:0]  BUS_BITS_RST = 3'h0;
  localparam logic [14:0] LP_CFG_RST   = 15'h0000;
  localparam logic [7:0]  ON_DLY_RST   = 8'h01;
  localparam logic [7:0]  OFF_DLY_RST  = 8'h01;
  localparam logic [7:0]  NORMAL_RST   = 8'h40;
  localparam logic [7:0]  SCALED_RST   = 8'h30;

  // Timing
  localparam int CLK_MHZ          = 10;
  localparam int SS_BUCK_US       = 1000;
  localparam int SS_BBST_US       = 10000;
  localparam int DELAY_TICK_US    = 100;
  localparam int SS_BUCK_CYCLES   = SS_BUCK_US * CLK_MHZ;
  localparam int SS_BBST_CYCLES   = SS_BBST_US * CLK_MHZ;
  localparam int DELAY_TICK_CYCLES = DELAY_TICK_US * CLK_MHZ;
  localparam int BBST_INDEX       = 4;

  // Trigger source codes
  localparam logic [2:0] TRIG_VIN    = 3'h5;
  localparam logic [2:0] TRIG_GPIO   = 3'h6;
  localparam logic [2:0] TRIG_ALWAYS = 3'h7;
  localparam logic [2:0] MIRROR_NONE = 3'h7;

  typedef enum logic [2:0] {
    SEQ_OFF      = 3'b000,
    SEQ_ON_WAIT  = 3'b001,
    SEQ_RAMP     = 3'b010,
    SEQ_ON       = 3'b011,
    SEQ_OFF_WAIT = 3'b100
  } seq_state_t;

  typedef enum logic [1:0] {
    TH_NORMAL = 2'b00,
    TH_FAULT  = 2'b01
  } therm_state_t;

  typedef struct packed {
    logic [7:0] off_delay;
    logic [7:0] on_delay;
  } delay_cfg_t;

  typedef struct packed {
    logic [7:0] scaled_setpoint;
    logic [7:0] normal_setpoint;
  } vset_t;

  typedef struct packed {
    logic                         thermal_shutdown_disable_main;
    logic                         thermal_shutdown_disable_aux;
    logic                         bus_scaling_enable;
    logic [1:0]                   bus_bit_sel;
    logic                         sleep_forces_scaling;
    logic                         scale_gpio_en;
    logic [2:0]                   scale_gpio;
    logic [NUM_OUT-1:0]           scale_mask;
    logic [NUM_OUT-1:0][2:0]      trig_sel;
    logic [NUM_OUT-1:0][2:0]      trig_gpio;
    logic [NUM_GPIO-1:0][2:0]     mirror_src;
  } factory_config_image_t;

  localparam factory_config_image_t FACTORY_RST = '{
    thermal_shutdown_disable_main: 1'b0,
    thermal_shutdown_disable_aux:  1'b1,
    bus_scaling_enable:            1'b1,
    bus_bit_sel:                   2'h0,
    sleep_forces_scaling:          1'b0,
    scale_gpio_en:                 1'b1,
    scale_gpio:                    3'h2,
    scale_mask:                    5'h0F,
    trig_sel:   {3'h3, 3'h2, 3'h1, 3'h0, 3'h5},
    trig_gpio:  {3'h0, 3'h0, 3'h0, 3'h0, 3'h0},
    mirror_src: {3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h4, 3'h7}
  };
endpackage
`default_nettype wire

/* hw/pmic_sequencer.sv */
// Implementation choices: register access over AHB-Lite and the register offsets.
`default_nettype none
module pmic_sequencer
  import pmic_seq_pkg::*;
#(
  parameter factory_config_image_t FACTORY      = FACTORY_RST,
  parameter int                    SS_BUCK_CYC  = SS_BUCK_CYCLES,
  parameter int                    SS_BBST_CYC  = SS_BBST_CYCLES,
  parameter int                    TICK_CYC     = DELAY_TICK_CYCLES
) (
  input  wire logic                       sys_clk,
  input  wire logic                       reset,
  // AHB-Lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  // Analog and system status
  input  wire logic                       over_temperature,
  input  wire logic                       aux_below_por,
  input  wire logic                       vin_power_ok,
  input  wire logic [NUM_OUT-1:0]         power_ok,
  input  wire logic                       sleep_state,
  input  wire logic                       deep_sleep_state,
  // GPIO pads
  input  wire logic [NUM_GPIO-1:0]        gpio_in,
  output logic      [NUM_GPIO-1:0]        gpio_out,
  output logic      [NUM_GPIO-1:0]        gpio_oe,
  // Regulator controls
  output logic      [NUM_OUT-1:0]         reg_enable,
  output logic      [NUM_OUT-1:0]         soft_start,
  output logic      [NUM_OUT-1:0][7:0]    setpoint,
  output logic                            aux_5v_output,
  output logic                            over_temperature_shutdown
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus and register state
  logic                      wr_pend_r;
  logic [7:0]                waddr_r;
  logic                      por_restart_r;
  logic [2:0]                bus_bits_r;
  logic [14:0]               lp_cfg_r;
  logic [31:0]               hrdata_r;
  logic                      hreadyout_r;
  logic                      hresp_r;
  logic                      regs_reset;
  logic                      addr_phase;
  logic [31:0]               status_word;
  logic [31:0]               rd_word;
  delay_cfg_t                delay_r   [NUM_OUT];
  vset_t                     vset_r    [NUM_OUT];

  // Thermal and scaling state
  therm_state_t              therm_r;
  logic                      aux_en_r;
  logic                      force_off;
  logic                      scale_active;
  logic                      scale_r;

  // Delay timebase
  logic [15:0]               tick_cnt_r;
  logic                      tick_r;

  logic [NUM_OUT-1:0]        enable_w;
  logic [NUM_OUT-1:0]        ramp_w;
  logic [NUM_OUT-1:0][7:0]   setpoint_w;
  logic [NUM_GPIO-1:0]       gpio_out_r;
  logic [NUM_GPIO-1:0]       gpio_oe_r;

  assign regs_reset = reset | por_restart_r;
  assign addr_phase = hsel & hready & htrans[1];

  // Bus response, zero wait states, always OKAY
  always_ff @(posedge sys_clk) begin
    hreadyout_r <= 1'b1;
    hresp_r     <= 1'b0;
  end

  // Write address capture
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
      waddr_r   <= 8'h00;
    end else begin
      wr_pend_r <= addr_phase & hwrite;
      waddr_r   <= haddr[7:0];
    end
  end

  // Status word
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_ENABLE_POS +: NUM_OUT] = enable_w;
    status_word[ST_RAMP_POS +: NUM_OUT]   = ramp_w;
    status_word[ST_AUX_POS]               = aux_en_r;
    status_word[ST_FAULT_POS]             = (therm_r == TH_FAULT);
    status_word[ST_SCALE_POS]             = scale_r;
  end

  // Read decode, unmapped reads zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      CTRL_OFS:   rd_word[BUS_BIT_POS +: 3] = bus_bits_r;
      STATUS_OFS: rd_word = status_word;
      LP_CFG_OFS: rd_word[14:0] = lp_cfg_r;
      default:    rd_word = 32'h0000_0000;
    endcase
    for (int k = 0; k < NUM_OUT; k++) begin
      if (haddr[7:0] == 8'(DELAY_BASE + REG_STRIDE * k)) begin
        rd_word[15:0] = delay_r[k];
      end
      if (haddr[7:0] == 8'(VSET_BASE + REG_STRIDE * k)) begin
        rd_word[15:0] = vset_r[k];
      end
    end
  end

  // Read data registered in the address phase
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_phase & ~hwrite) begin
      hrdata_r <= rd_word;
    end
  end

  // Control and low-power configuration
  always_ff @(posedge sys_clk) begin
    if (regs_reset) begin
      bus_bits_r <= BUS_BITS_RST;
      lp_cfg_r   <= LP_CFG_RST;
    end else if (wr_pend_r) begin
      if (waddr_r == CTRL_OFS) begin
        bus_bits_r <= hwdata[BUS_BIT_POS +: 3];
      end
      if (waddr_r == LP_CFG_OFS) begin
        lp_cfg_r <= hwdata[14:0];
      end
    end
  end

  // Delay timebase tick
  // Delays in ticks
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 16'(TICK_CYC - 1)) begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r     <= 1'b0;
    end
  end

  // Thermal fault state and aux output
  // Fixed-threshold shutdown entry
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      therm_r       <= TH_NORMAL;
      aux_en_r      <= 1'b1;
      por_restart_r <= 1'b0;
    end else begin
      por_restart_r <= 1'b0;
      case (therm_r)
        TH_NORMAL: begin
          aux_en_r <= 1'b1;
          if (over_temperature & ~(FACTORY.thermal_shutdown_disable_main &
                                   FACTORY.thermal_shutdown_disable_aux)) begin
            therm_r <= TH_FAULT;
            aux_en_r <= FACTORY.thermal_shutdown_disable_aux;
          end
        end
        TH_FAULT: begin
          if (FACTORY.thermal_shutdown_disable_main) begin
            if (aux_below_por) begin
              therm_r  <= TH_NORMAL;
              aux_en_r <= 1'b1;
            end
          end else begin
            if (aux_below_por & ~aux_en_r) begin
              por_restart_r <= 1'b1;
            end
            if (~over_temperature) begin
              therm_r  <= TH_NORMAL;
              aux_en_r <= 1'b1;
            end
          end
        end
        default: begin
          therm_r  <= TH_NORMAL;
          aux_en_r <= 1'b1;
        end
      endcase
    end
  end

  assign force_off = (therm_r == TH_FAULT) & ~FACTORY.thermal_shutdown_disable_main;

  // Group scaling trigger
  always_comb begin
    scale_active = 1'b0;
    if (FACTORY.scale_gpio_en & gpio_in[FACTORY.scale_gpio]) begin
      scale_active = 1'b1;
    end
    if (FACTORY.bus_scaling_enable & bus_bits_r[FACTORY.bus_bit_sel]) begin
      scale_active = 1'b1;
    end
    if (FACTORY.sleep_forces_scaling & sleep_state) begin
      scale_active = 1'b1;
    end
  end

  // Registered scaling flag for status
  always_ff @(posedge sys_clk) begin
    scale_r <= ~reset & scale_active;
  end

  // Per-output sequencer, registers and setpoint
  // Five sequenced outputs
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    localparam int SS_CYC = (i == BBST_INDEX) ? SS_BBST_CYC : SS_BUCK_CYC;
    seq_state_t  state_r;
    logic [7:0]  dly_cnt_r;
    logic [16:0] ss_cnt_r;
    logic        en_r;
    logic        ramp_r;
    logic [7:0]  set_r;
    logic        trig;
    logic        off_now;
    logic        use_alt;

    // Delay and voltage registers, volatile
    // Writable volatile on delay
    always_ff @(posedge sys_clk) begin
      if (regs_reset) begin
        delay_r[i] <= '{off_delay: OFF_DLY_RST, on_delay: ON_DLY_RST};
        vset_r[i]  <= '{scaled_setpoint: SCALED_RST, normal_setpoint: NORMAL_RST};
      end else if (wr_pend_r) begin
        if (waddr_r == 8'(DELAY_BASE + REG_STRIDE * i)) begin
          delay_r[i] <= hwdata[15:0];
        end
        if (waddr_r == 8'(VSET_BASE + REG_STRIDE * i)) begin
          vset_r[i] <= hwdata[15:0];
        end
      end
    end

    // Trigger selection
    // Trigger source select
    always_comb begin
      case (FACTORY.trig_sel[i])
        TRIG_VIN:    trig = vin_power_ok;
        TRIG_GPIO:   trig = gpio_in[FACTORY.trig_gpio[i]];
        TRIG_ALWAYS: trig = 1'b1;
        default:     trig = (FACTORY.trig_sel[i] < 3'(NUM_OUT)) ?
                            power_ok[FACTORY.trig_sel[i]] : 1'b0;
      endcase
    end

    assign off_now = force_off | (deep_sleep_state & lp_cfg_r[LP_OFF_POS + i]);

    // Sequencer state machine
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        state_r   <= SEQ_OFF;
        dly_cnt_r <= 8'h00;
        ss_cnt_r  <= 17'h00000;
        en_r      <= 1'b0;
        ramp_r    <= 1'b0;
      end else if (off_now) begin
        state_r <= SEQ_OFF;
        en_r    <= 1'b0;
        ramp_r  <= 1'b0;
      end else begin
        case (state_r)
          SEQ_OFF: begin
            if (trig) begin
              state_r   <= SEQ_ON_WAIT;
              dly_cnt_r <= 8'h00;
            end
          end
          SEQ_ON_WAIT: begin
            if (~trig) begin
              state_r <= SEQ_OFF;
            end else if (dly_cnt_r >= delay_r[i].on_delay) begin
              state_r  <= SEQ_RAMP;
              en_r     <= 1'b1;
              ramp_r   <= 1'b1;
              ss_cnt_r <= 17'h00000;
            end else if (tick_r) begin
              dly_cnt_r <= dly_cnt_r + 8'h01;
            end
          end
          SEQ_RAMP: begin
            if (ss_cnt_r == 17'(SS_CYC - 1)) begin
              state_r <= SEQ_ON;
              ramp_r  <= 1'b0;
            end else begin
              ss_cnt_r <= ss_cnt_r + 17'h00001;
            end
          end
          SEQ_ON: begin
            if (~trig) begin
              state_r   <= SEQ_OFF_WAIT;
              dly_cnt_r <= 8'h00;
            end
          end
          SEQ_OFF_WAIT: begin
            if (trig) begin
              state_r <= SEQ_ON;
            end else if (dly_cnt_r >= delay_r[i].off_delay) begin
              state_r <= SEQ_OFF;
              en_r    <= 1'b0;
            end else if (tick_r) begin
              dly_cnt_r <= dly_cnt_r + 8'h01;
            end
          end
          default: begin
            state_r <= SEQ_OFF;
            en_r    <= 1'b0;
            ramp_r  <= 1'b0;
          end
        endcase
      end
    end

    // Alternate setpoint selection
    // Group scaling on masked converters only, sleep and deep-sleep alternates on any output set in lp_cfg_r
    assign use_alt = (scale_active & FACTORY.scale_mask[i]) |
                     (sleep_state & lp_cfg_r[LP_SLEEP_POS + i]) |
                     (deep_sleep_state & lp_cfg_r[LP_DEEP_POS + i]);

    // Setpoint register
    // Active or alternate setpoint
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        set_r <= NORMAL_RST;
      end else begin
        set_r <= use_alt ? vset_r[i].scaled_setpoint : vset_r[i].normal_setpoint;
      end
    end

    assign enable_w[i]   = en_r;
    assign ramp_w[i]     = ramp_r;
    assign setpoint_w[i] = set_r;
  end

  // GPIO power-ok mirror
  // GPIO mirrors internal power-ok
  for (genvar g = 0; g < NUM_GPIO; g++) begin : g_gpio
    always_ff @(posedge sys_clk) begin
      if (~reset & (FACTORY.mirror_src[g] < 3'(NUM_OUT))) begin
        gpio_out_r[g] <= power_ok[FACTORY.mirror_src[g]];
        gpio_oe_r[g]  <= 1'b1;
      end else begin
        gpio_out_r[g] <= 1'b0;
        gpio_oe_r[g]  <= 1'b0;
      end
    end
  end

  assign hrdata                    = hrdata_r;
  assign hreadyout                 = hreadyout_r;
  assign hresp                     = hresp_r;
  assign gpio_out                  = gpio_out_r;
  assign gpio_oe                   = gpio_oe_r;
  assign reg_enable                = enable_w;
  assign soft_start                = ramp_w;
  assign setpoint                  = setpoint_w;
  assign aux_5v_output             = aux_en_r;
  assign over_temperature_shutdown = (therm_r == TH_FAULT);

endmodule // pmic_sequencer
`default_nettype wire

/* sim/pmic_sequencer_checker.sv */
`default_nettype none
module pmic_sequencer_checker
  import pmic_seq_pkg::*;
#(
  parameter factory_config_image_t FACTORY     = FACTORY_RST,
  parameter int                    SS_BUCK_CYC = SS_BUCK_CYCLES,
  parameter int                    SS_BBST_CYC = SS_BBST_CYCLES
) (
  input wire logic               sys_clk,
  input wire logic               reset,
  input wire logic               over_temperature,
  input wire logic               aux_below_por,
  input wire logic [NUM_OUT-1:0] power_ok,
  input wire logic [NUM_GPIO-1:0] gpio_out,
  input wire logic [NUM_GPIO-1:0] gpio_oe,
  input wire logic [NUM_OUT-1:0] reg_enable,
  input wire logic [NUM_OUT-1:0] soft_start,
  input wire logic               aux_5v_output,
  input wire logic               over_temperature_shutdown
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic KEEP_MAIN = FACTORY.thermal_shutdown_disable_main;
  localparam logic KEEP_AUX  = FACTORY.thermal_shutdown_disable_aux;
  int unsigned ss_buck_r;
  int unsigned ss_bbst_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Length of the first buck ramp window
  always_ff @(posedge sys_clk) begin
    ss_buck_r <= soft_start[0] ? ss_buck_r + 1 : 0;
  end

  // Length of the buck-boost ramp window
  always_ff @(posedge sys_clk) begin
    ss_bbst_r <= soft_start[BBST_INDEX] ? ss_bbst_r + 1 : 0;
  end

  a_fault_entry: assert property (
    over_temperature && !aux_below_por && !(KEEP_MAIN && KEEP_AUX) |=> over_temperature_shutdown)
    else $error("thermal fault not entered");
  a_fault_exit: assert property (
    over_temperature_shutdown && !over_temperature && !KEEP_MAIN |=> !over_temperature_shutdown)
    else $error("thermal fault not left");
  a_fault_forces_off: assert property (
    over_temperature_shutdown && !KEEP_MAIN |=> reg_enable == '0)
    else $error("regulator on during thermal fault");
  a_aux_held_on: assert property (KEEP_AUX |-> aux_5v_output)
    else $error("aux output dropped");
  a_start_on_trigger: assert property (
    $rose(reg_enable[1]) |-> power_ok[0] && $past(power_ok[0]))
    else $error("output started without trigger");
  a_ramp_with_enable: assert property (
    ((reg_enable & ~$past(reg_enable) & ~soft_start) | (soft_start & ~reg_enable)) == '0)
    else $error("ramp window not tied to enable");
  a_ss_buck_len: assert property (
    $fell(soft_start[0]) && reg_enable[0] |-> ss_buck_r == SS_BUCK_CYC)
    else $error("buck soft-start length wrong");
  a_ss_bbst_len: assert property (
    $fell(soft_start[BBST_INDEX]) && reg_enable[BBST_INDEX] |-> ss_bbst_r == SS_BBST_CYC)
    else $error("buck-boost soft-start length wrong");
  a_gpio_mirror: assert property (
    $rose(power_ok[4]) && gpio_oe[1] |-> ##[0:2] gpio_out[1])
    else $error("gpio does not mirror power-ok");
endmodule // pmic_sequencer_checker

bind pmic_sequencer pmic_sequencer_checker #(
  .FACTORY(FACTORY), .SS_BUCK_CYC(SS_BUCK_CYC), .SS_BBST_CYC(SS_BBST_CYC)
) chk_i (
  .sys_clk, .reset, .over_temperature, .aux_below_por, .power_ok, .gpio_out, .gpio_oe,
  .reg_enable, .soft_start, .aux_5v_output, .over_temperature_shutdown
);
`default_nettype wire

/* sim/supply_model.sv */
`default_nettype none
module supply_model
  import pmic_seq_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               stall,
  input  wire logic [NUM_OUT-1:0] reg_enable,
  input  wire logic [NUM_OUT-1:0] soft_start,
  output logic      [NUM_OUT-1:0] power_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NUM_OUT-1:0] ok_r;

  // power-ok feeds triggers
  // In regulation once enabled and the ramp is over
  always_ff @(posedge sys_clk) begin
    ok_r <= reg_enable & ~soft_start;
  end

  // Slow supply holds power-ok low
  assign power_ok = stall ? '0 : ok_r;
endmodule // supply_model
`default_nettype wire

/* sim/pmic_sequence_thermal_dvs_test.sv */
`default_nettype none
module pmic_sequence_thermal_dvs_test
  import pmic_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 4;
  typedef struct packed {
    logic        wr;
    logic [7:0]  ofs;
    logic [31:0] wdat;
    logic [31:0] exp;
  } row_t;
  logic                    sys_clk = 1'b0;
  logic                    reset = 1'b1;
  logic [31:0]             haddr = '0;
  logic [31:0]             hwdata = '0;
  logic [1:0]              htrans = 2'h0;
  logic                    hwrite = 1'b0;
  logic                    over_temperature = 1'b0;
  logic                    vin_power_ok = 1'b0;
  logic                    sleep_state = 1'b0;
  logic                    deep_sleep_state = 1'b0;
  logic                    stall = 1'b1;
  logic [NUM_GPIO-1:0]     gpio_drv = '0;
  logic [NUM_GPIO-1:0]     gpio_in, gpio_out, gpio_oe;
  logic [NUM_OUT-1:0]      power_ok, reg_enable, soft_start;
  logic [NUM_OUT-1:0][7:0] setpoint;
  logic [31:0]             hrdata, rd;
  logic                    hreadyout, hresp, aux_5v_output, over_temperature_shutdown;
  int                      mismatches = 0;
  int                      n_tests = 0;
  int                      n;
  // Second image: main regulators kept, aux cut in a fault
  localparam factory_config_image_t FACTORY_B = {2'b10, FACTORY_RST[63:0]};
  logic                    aux_low = 1'b0;
  logic [NUM_OUT-1:0]      reg_enable_b;
  logic                    aux_b, ots_b;
  row_t rows [8] = '{
    '{1'b0, DELAY_BASE, 32'h0, {16'h0, OFF_DLY_RST, ON_DLY_RST}},
    '{1'b0, VSET_BASE + 8'h10, 32'h0, {16'h0, SCALED_RST, NORMAL_RST}},
    '{1'b0, LP_CFG_OFS, 32'h0, 32'h0},
    '{1'b1, 8'hFC, 32'hFFFF_FFFF, 32'h0},
    '{1'b1, CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0E00},
    '{1'b1, CTRL_OFS, 32'h0, 32'h0},
    '{1'b1, DELAY_BASE, 32'h0000_0103, 32'h0000_0103},
    '{1'b1, VSET_BASE + 8'h0C, 32'hFFFF_1234, 32'h0000_1234}
  };

  always #50 sys_clk = ~sys_clk;
  // Pad level from both drivers
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & gpio_drv);

  pmic_sequencer #(.SS_BUCK_CYC(20), .SS_BBST_CYC(50), .TICK_CYC(TICK)) dut (
    .sys_clk, .reset, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .over_temperature,
    .aux_below_por(1'b0), .vin_power_ok, .power_ok, .sleep_state, .deep_sleep_state,
    .gpio_in, .gpio_out, .gpio_oe, .reg_enable, .soft_start, .setpoint, .aux_5v_output,
    .over_temperature_shutdown);
  supply_model sup (.sys_clk, .stall, .reg_enable, .soft_start, .power_ok);
  pmic_sequencer #(.FACTORY(FACTORY_B), .SS_BUCK_CYC(20), .SS_BBST_CYC(50),
    .TICK_CYC(TICK)) dut_b (
    .sys_clk, .reset, .hsel(1'b0), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(1'b1), .hrdata(), .hreadyout(), .hresp(), .over_temperature,
    .aux_below_por(aux_low), .vin_power_ok, .power_ok, .sleep_state, .deep_sleep_state,
    .gpio_in, .gpio_out(), .gpio_oe(), .reg_enable(reg_enable_b), .soft_start(),
    .setpoint(), .aux_5v_output(aux_b), .over_temperature_shutdown(ots_b));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One single transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic wt(input logic [4:0] m);
    for (int k = 0; k < 3000 && {reg_enable, soft_start} !== {m, 5'h0}; k++) cyc(1);
    chk("enables", {27'h0, reg_enable}, {27'h0, m});
  endtask
  task automatic cnt_to(input logic v);
    for (n = 0; n < 200 && reg_enable[0] !== v; n++) cyc(1);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    cyc(20000);
    mismatches++;
    summarize();
  end

  initial begin
    cyc(4);
    reset <= 1'b0;
    cyc(1);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].ofs, rows[i].wdat);
      bus(1'b0, rows[i].ofs, 32'h0);
      chk("register", rd, rows[i].exp);
      chk("bus okay", {30'h0, hreadyout, hresp}, 32'h2);
    end
    $display("test registers done");
    vin_power_ok <= 1'b1;
    cnt_to(1'b1);
    chk("on delay", 32'(n >= 2 * TICK && n <= 4 * TICK + 4), 32'h1);
    cyc(40);
    chk("held by trigger", {31'h0, reg_enable[1]}, 32'h0);
    stall <= 1'b0;
    wt(5'h1F);
    cyc(3);
    chk("active vset", {24'h0, setpoint[3]}, 32'h34);
    chk("mirror", {30'h0, gpio_oe[1], gpio_in[1]}, 32'h3);
    $display("test sequencing done");
    gpio_drv[2] <= 1'b1;
    cyc(6);
    chk("gpio scaled", {8'h0, setpoint[4], setpoint[3], setpoint[0]},
        {8'h0, NORMAL_RST, 8'h12, SCALED_RST});
    gpio_drv[2] <= 1'b0;
    cyc(6);
    chk("gpio normal", {24'h0, setpoint[0]}, {24'h0, NORMAL_RST});
    for (int b = 0; b < 3; b++) begin
      bus(1'b1, CTRL_OFS, 32'h200 << b);
      cyc(4);
      chk("bus scaling", {24'h0, setpoint[1]}, {24'h0, b == 0 ? SCALED_RST : NORMAL_RST});
    end
    bus(1'b1, CTRL_OFS, 32'h0);
    sleep_state <= 1'b1;
    cyc(4);
    chk("sleep no scale", {24'h0, setpoint[1]}, {24'h0, NORMAL_RST});
    sleep_state <= 1'b0;
    // large change made in small steps
    bus(1'b1, VSET_BASE, {16'h0, SCALED_RST, 8'h3A});
    bus(1'b1, VSET_BASE, {16'h0, SCALED_RST, 8'h34});
    cyc(4);
    chk("direct vset", {24'h0, setpoint[0]}, 32'h34);
    $display("test scaling done");
    bus(1'b1, LP_CFG_OFS, 32'h1);
    deep_sleep_state <= 1'b1;
    cyc(3);
    chk("deep off", {31'h0, reg_enable[0]}, 32'h0);
    deep_sleep_state <= 1'b0;
    cnt_to(1'b1);
    chk("deep restart", 32'(n >= 2 * TICK), 32'h1);
    wt(5'h1F);
    bus(1'b1, LP_CFG_OFS, 32'h0);
    bus(1'b1, DELAY_BASE, 32'h0000_0403);
    vin_power_ok <= 1'b0;
    cnt_to(1'b0);
    chk("off delay", 32'(n >= 3 * TICK && n <= 5 * TICK + 4), 32'h1);
    vin_power_ok <= 1'b1;
    wt(5'h1F);
    $display("test delays done");
    over_temperature <= 1'b1;
    cyc(4);
    chk("thermal", {29'h0, over_temperature_shutdown, aux_5v_output, |reg_enable},
        32'h6);
    chk("thermal keep", {29'h0, ots_b, aux_b, reg_enable_b[0]}, 32'h5);
    over_temperature <= 1'b0;
    cyc(3);
    chk("thermal exit", {31'h0, over_temperature_shutdown}, 32'h0);
    chk("aux held off", {30'h0, ots_b, aux_b}, 32'h2);
    aux_low <= 1'b1;
    cyc(2);
    aux_low <= 1'b0;
    chk("aux back", {30'h0, ots_b, aux_b}, 32'h1);
    wt(5'h1F);
    bus(1'b0, DELAY_BASE, 32'h0);
    chk("kept regs", rd, 32'h0000_0403);
    $display("test thermal done");
    reset <= 1'b1;
    cyc(4);
    chk("reset outs", {19'h0, reg_enable, setpoint[0]}, {24'h0, NORMAL_RST});
    reset <= 1'b0;
    cyc(1);
    bus(1'b0, DELAY_BASE, 32'h0);
    chk("reset delay", rd, {16'h0, OFF_DLY_RST, ON_DLY_RST});
    $display("test reset done");
    summarize();
  end
endmodule // pmic_sequence_thermal_dvs_test
`default_nettype wire
